// *** include/flash_guard_pkg.sv ***
package flash_guard_pkg;

  // ==========================================================
  // Register addresses on the special-function register port.
  localparam logic [7:0] ADDR_PROGRAM_STORE_CONTROL = 8'h8f;
  localparam logic [7:0] ADDR_FLASH_CONTROL = 8'hb6;
  // The limit register has no printed address; this one is a free slot.
  localparam logic [7:0] ADDR_ACCESS_LIMIT = 8'hb7;

  // ==========================================================
  // Reset values.
  localparam logic [7:0] RESET_PROGRAM_STORE_CONTROL = 8'h00;
  localparam logic [7:0] RESET_FLASH_CONTROL = 8'h80;
  localparam logic [7:0] RESET_ACCESS_LIMIT = 8'h00;

  // ==========================================================
  // Field positions.
  localparam int FC_ONE_SHOT_BIT = 7;
  localparam int FC_READ_ALWAYS_BIT = 6;
  localparam int FC_WRITE_ENABLE_BIT = 0;
  localparam logic [7:0] FC_WRITABLE_MASK = 8'hc1;
  localparam int PSC_SCRATCHPAD_BIT = 2;
  localparam int PSC_ERASE_ENABLE_BIT = 1;
  localparam int PSC_WRITE_ENABLE_BIT = 0;
  localparam logic [7:0] PSC_WRITABLE_MASK = 8'h07;

  // ==========================================================
  // Flash geometry and values.
  localparam int ADDR_W = 16;
  localparam int PAGE_BITS = 9;
  localparam int SCRATCH_BITS = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BLOCKED_BYTE = 8'h00;
  localparam logic [7:0] LIMIT_LOW_BYTE = 8'h00;
  localparam logic [15:0] READ_LOCK_ADDR = 16'hfdff;
  localparam logic [15:0] WRITE_LOCK_ADDR = 16'hfdfe;
  localparam logic [15:0] LOCK_PAGE_FIRST = 16'hfbff;
  localparam logic [15:0] LOCK_PAGE_LAST = 16'hfdff;
  localparam int BLOCK_SHIFT = 13;

  // ==========================================================
  // Timing.
  localparam int CLK_MHZ = 25;
  localparam int WRITE_TIME_US = 40;
  localparam int ERASE_TIME_MS = 10;
  localparam int ONE_SHOT_NS = 80;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int ONE_SHOT_CYCLES = (ONE_SHOT_NS * CLK_MHZ + 999) / 1000;

  // Operation sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_ERASE_PAGE,
    ST_ERASE_ALL,
    ST_DONE
  } op_state_type;

endpackage

// *** logic/flash_byte_store.sv ***
`timescale 1ns/1ps
`default_nettype none

// Byte-wide flash array model: erase of a span sets bytes, writes only clear bits.
module flash_byte_store
  import flash_guard_pkg::*;
#(
  parameter int AW = 17
) (
  // Clock.
  input wire logic clk,
  // Port controls.
  input wire logic rd_en,
  input wire logic wr_en,
  // High while the write is part of an erase, so the byte goes back to all ones.
  input wire logic erase_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  // Read data, registered.
  output logic [7:0] rdata
);

  // ==========================================================
  // Storage.
  logic [7:0] mem [0:(1<<AW)-1];

  // Programming ANDs the new byte in so it can only clear bits; erase sets them.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= erase_en ? ERASED_BYTE : (mem[addr] & wdata);
    end
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// *** logic/flash_access_guard.sv ***
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Limit address is limit byte then zero.
// R2: Upper code cannot touch lower flash.
// R3: Blocked reads return zero byte.
// R4: Lower code accesses both partitions freely.
// R5: Fetches below limit always allowed.
// R6: Limit register accepts first write only.
// R7: Zero limit leaves everything readable.
// R8: Lock bits always readable and clearable.
// R9: Only JTAG full erase removes locks; here a JTAG lock-page erase clears them too.
// R10: JTAG erase of lock byte erases all.
// R11: JTAG erase in lock page erases page.
// R12: Control bit7 enables sense one-shot timer.
// R13: Control bit6 keeps flash in read.
// R14: Control bits 5..1 read zero.
// R15: Software write/erase needs control bit0.
// R16: Scratchpad select redirects to 128-byte sector.
// R17: Erase plus write enable erases page.
// R18: Write enable alone programs the byte.
// R19: Store control bits 7..3 read zero.
// R20: Limit should sit on 512-byte boundary.
// R21: 512-byte pages, erase to ff, writes clear.
// R22: Stall core during write or erase.
// R23: Two lock bytes, 8k blocks, zero locks; here the lock bytes only drive READ_LOCK and WRITE_LOCK and block nothing.
// R24: Data-move reads always go to RAM.
// R25: Partition taken from issuing instruction's address.
module flash_access_guard
  import flash_guard_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Special-function register port.
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Core access: code reads, data-move writes, fetches.
  input wire logic CODE_RD,
  input wire logic DATA_MOVE_WR,
  input wire logic DATA_MOVE_RD,
  input wire logic FETCH,
  input wire logic [15:0] ACC_ADDR,
  input wire logic [15:0] ACC_PC,
  input wire logic [7:0] ACC_WDATA,
  output logic [7:0] ACC_RDATA,
  output logic ACC_RVALID,
  output logic XRAM_SEL,
  output logic CORE_STALL,
  // JTAG erase request.
  input wire logic JTAG_ERASE,
  input wire logic [15:0] JTAG_ADDR,
  // Flash analog controls and status.
  output logic SENSE_AMP_ON,
  output logic [7:0] READ_LOCK,
  output logic [7:0] WRITE_LOCK
);

  // ==========================================================
  // Registers.
  logic [7:0] psc_r, psc_nxt; // Store control.
  logic [7:0] fc_r, fc_nxt; // Flash control.
  logic [7:0] lim_r, lim_nxt; // Limit high byte.
  logic lim_locked_r, lim_locked_nxt; // Set after the first limit write.
  op_state_type st_r, st_nxt; // Operation sequencer.
  logic [31:0] cnt_r, cnt_nxt; // Operation timer.
  logic [16:0] op_addr_r, op_addr_nxt; // Array address of the current op.
  logic [16:0] end_addr_r, end_addr_nxt; // Last address of an erase span.
  logic [7:0] op_data_r, op_data_nxt; // Byte to program.
  logic [3:0] shot_r, shot_nxt; // Sense amp one-shot counter.
  logic rvalid_r, rvalid_nxt; // Read data valid next cycle.
  logic blocked_r, blocked_nxt; // Current read was blocked.

  // Array port.
  logic arr_rd, arr_wr;
  logic [16:0] arr_addr;
  logic [7:0] arr_wdata, arr_rdata;

  // ==========================================================
  // Decoding helpers.
  // Limit address from the high byte with zero low byte.
  function automatic logic [15:0] limit_addr(input logic [7:0] hi);
    limit_addr = {hi, LIMIT_LOW_BYTE}; // R1
  endfunction

  // Maps a software address into the array, honouring scratchpad selection.
  // The scratchpad lives above the main 64k; out-of-range offsets wrap to their low seven bits.
  function automatic logic [16:0] soft_map(input logic [15:0] a, input logic scr);
    soft_map = scr ? {1'b1, 9'h000, a[SCRATCH_BITS-1:0]} : {1'b0, a}; // R16
  endfunction

  logic [15:0] lim_addr;
  logic upper_code, lower_target, guard_hit;
  assign lim_addr = limit_addr(lim_r);
  // Zero limit makes every target at or above it, so nothing is blocked.
  assign upper_code = (ACC_PC >= lim_addr); // R25
  assign lower_target = (ACC_ADDR < lim_addr); // R7
  assign guard_hit = upper_code && lower_target && !psc_r[PSC_SCRATCHPAD_BIT]; // R2 R4

  logic sw_wr_ok;
  assign sw_wr_ok = fc_r[FC_WRITE_ENABLE_BIT] && psc_r[PSC_WRITE_ENABLE_BIT]; // R15

  // The sector that holds the lock bytes may be programmed but never erased by
  // software; otherwise firmware could wipe its own locks.
  logic lock_page_erase;
  assign lock_page_erase = psc_r[PSC_ERASE_ENABLE_BIT] && !psc_r[PSC_SCRATCHPAD_BIT] &&
    (ACC_ADDR[15:PAGE_BITS] == READ_LOCK_ADDR[15:PAGE_BITS]); // R9

  // ==========================================================
  // Register file next state.
  always_comb begin
    psc_nxt = psc_r;
    fc_nxt = fc_r;
    lim_nxt = lim_r;
    lim_locked_nxt = lim_locked_r;
    if (SFR_WR) begin
      unique case (SFR_ADDR)
        ADDR_PROGRAM_STORE_CONTROL: begin
          psc_nxt = SFR_WDATA & PSC_WRITABLE_MASK; // R19
        end
        ADDR_FLASH_CONTROL: begin
          fc_nxt = SFR_WDATA & FC_WRITABLE_MASK; // R14
        end
        ADDR_ACCESS_LIMIT: begin
          // Only the first write after reset lands; software should pick
          // an even value so the limit sits on a page boundary.
          if (!lim_locked_r) begin
            lim_nxt = SFR_WDATA; // R6 R20
            lim_locked_nxt = 1'b1; // R6
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Register file state.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      psc_r <= RESET_PROGRAM_STORE_CONTROL;
      fc_r <= RESET_FLASH_CONTROL;
      lim_r <= RESET_ACCESS_LIMIT;
      lim_locked_r <= 1'b0;
    end else begin
      psc_r <= psc_nxt;
      fc_r <= fc_nxt;
      lim_r <= lim_nxt;
      lim_locked_r <= lim_locked_nxt;
    end
  end

  // Register read mux; unmapped addresses read zero.
  always_comb begin
    SFR_RDATA = 8'h00;
    if (SFR_RD) begin
      unique case (SFR_ADDR)
        ADDR_PROGRAM_STORE_CONTROL: SFR_RDATA = psc_r;
        ADDR_FLASH_CONTROL: SFR_RDATA = fc_r;
        ADDR_ACCESS_LIMIT: SFR_RDATA = lim_r;
        default: SFR_RDATA = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Operation sequencer: starts writes and erases, walks erase spans.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    op_addr_nxt = op_addr_r;
    end_addr_nxt = end_addr_r;
    op_data_nxt = op_data_r;
    arr_wr = 1'b0;
    arr_wdata = ERASED_BYTE;
    unique case (st_r)
      ST_IDLE: begin
        if (JTAG_ERASE) begin
          // Lock bytes fall only to JTAG: an erase of the main 64k, or the lock-page erase whose span ends on them.
          if (JTAG_ADDR == READ_LOCK_ADDR || JTAG_ADDR == WRITE_LOCK_ADDR) begin
            op_addr_nxt = 17'h00000; // R9 R10
            end_addr_nxt = 17'h0ffff; // R10
            st_nxt = ST_ERASE_ALL;
          end else if (JTAG_ADDR >= LOCK_PAGE_FIRST && JTAG_ADDR <= LOCK_PAGE_LAST) begin
            op_addr_nxt = {1'b0, LOCK_PAGE_FIRST}; // R11
            end_addr_nxt = {1'b0, LOCK_PAGE_LAST}; // R11
            st_nxt = ST_ERASE_PAGE;
          end else begin
            op_addr_nxt = {1'b0, JTAG_ADDR[15:PAGE_BITS], 9'h000}; // R21
            end_addr_nxt = {1'b0, JTAG_ADDR[15:PAGE_BITS], 9'h1ff};
            st_nxt = ST_ERASE_PAGE;
          end
          cnt_nxt = 32'(ERASE_CYC);
        end else if (DATA_MOVE_WR && sw_wr_ok && !guard_hit && !lock_page_erase) begin
          if (psc_r[PSC_ERASE_ENABLE_BIT]) begin
            // Data byte is ignored; the whole page, or the 128-byte scratchpad sector, containing the address goes.
            op_addr_nxt = soft_map(ACC_ADDR, psc_r[PSC_SCRATCHPAD_BIT]); // R17
            if (psc_r[PSC_SCRATCHPAD_BIT]) begin
              op_addr_nxt[SCRATCH_BITS-1:0] = 7'h00;
              end_addr_nxt = {op_addr_nxt[16:SCRATCH_BITS], 7'h7f};
            end else begin
              op_addr_nxt[PAGE_BITS-1:0] = 9'h000; // R21
              end_addr_nxt = {op_addr_nxt[16:PAGE_BITS], 9'h1ff};
            end
            cnt_nxt = 32'(ERASE_CYC);
            st_nxt = ST_ERASE_PAGE;
          end else begin
            // Location is expected to be erased already.
            op_addr_nxt = soft_map(ACC_ADDR, psc_r[PSC_SCRATCHPAD_BIT]); // R18
            op_data_nxt = ACC_WDATA; // R18
            cnt_nxt = 32'(WRITE_CYC);
            st_nxt = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        if (cnt_r == 32'd1) begin
          arr_wr = 1'b1;
          arr_wdata = op_data_r; // R21
          st_nxt = ST_DONE;
        end
        cnt_nxt = cnt_r - 32'd1;
      end
      ST_ERASE_PAGE, ST_ERASE_ALL: begin
        // One byte set to the erased value per cycle; done once the span is walked and the timer has run out.
        if (op_addr_r != end_addr_r + 17'h00001) begin
          arr_wr = 1'b1;
          op_addr_nxt = op_addr_r + 17'h00001;
        end
        if (cnt_r <= 32'd1 && op_addr_r == end_addr_r + 17'h00001) begin
          st_nxt = ST_DONE;
        end
        if (cnt_r != 32'd0) begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      ST_DONE: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= ST_IDLE;
      cnt_r <= 32'd0;
      op_addr_r <= 17'h00000;
      end_addr_r <= 17'h00000;
      op_data_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      op_addr_r <= op_addr_nxt;
      end_addr_r <= end_addr_nxt;
      op_data_r <= op_data_nxt;
    end
  end

  // The core waits while the array is busy; its interrupts just stay pending.
  assign CORE_STALL = (st_r != ST_IDLE); // R22

  // ==========================================================
  // Read path and sense amp control.
  logic do_read;
  // Fetches are never guarded so published lower entry points still run.
  assign do_read = (st_r == ST_IDLE) && (CODE_RD || FETCH); // R5
  assign arr_rd = do_read;
  assign arr_addr = (st_r == ST_IDLE) ?
    (FETCH ? {1'b0, ACC_PC} : soft_map(ACC_ADDR, psc_r[PSC_SCRATCHPAD_BIT])) : op_addr_r;
  // Array writes made while erasing set the byte instead of clearing bits.
  logic arr_erase;
  assign arr_erase = (st_r == ST_ERASE_PAGE) || (st_r == ST_ERASE_ALL); // R21

  always_comb begin
    rvalid_nxt = do_read;
    blocked_nxt = CODE_RD && !FETCH && guard_hit; // R3
    shot_nxt = shot_r;
    if (do_read) begin
      shot_nxt = 4'(ONE_SHOT_CYCLES); // R12
    end else if (shot_r != 4'h0) begin
      shot_nxt = shot_r - 4'h1;
    end
  end

  // Read state.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_r <= 1'b0;
      blocked_r <= 1'b0;
      shot_r <= 4'h0;
    end else begin
      rvalid_r <= rvalid_nxt;
      blocked_r <= blocked_nxt;
      shot_r <= shot_nxt;
    end
  end

  assign ACC_RVALID = rvalid_r;
  assign ACC_RDATA = blocked_r ? BLOCKED_BYTE : arr_rdata; // R3
  // Data-move reads never reach flash.
  assign XRAM_SEL = DATA_MOVE_RD || (DATA_MOVE_WR && !psc_r[PSC_WRITE_ENABLE_BIT]); // R24
  // Read-always wins; otherwise the one-shot or, if disabled, always on.
  assign SENSE_AMP_ON = fc_r[FC_READ_ALWAYS_BIT] || !fc_r[FC_ONE_SHOT_BIT] ||
    (shot_r != 4'h0) || do_read; // R12 R13

  // Lock bytes are plain array bytes, always readable; bits clear by programming.
  logic [7:0] rlock_r, wlock_r;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rlock_r <= ERASED_BYTE;
      wlock_r <= ERASED_BYTE;
    end else if (arr_wr && arr_addr == {1'b0, READ_LOCK_ADDR}) begin
      rlock_r <= (st_r == ST_WRITE) ? (rlock_r & arr_wdata) : ERASED_BYTE; // R8 R23
    end else if (arr_wr && arr_addr == {1'b0, WRITE_LOCK_ADDR}) begin
      wlock_r <= (st_r == ST_WRITE) ? (wlock_r & arr_wdata) : ERASED_BYTE; // R8 R23
    end
  end
  assign READ_LOCK = rlock_r;
  assign WRITE_LOCK = wlock_r;

  // ==========================================================
  // Flash array.
  flash_byte_store #(
    .AW(17)
  ) u_store (
    .clk(CLK),
    .rd_en(arr_rd),
    .wr_en(arr_wr),
    .erase_en(arr_erase),
    .addr(arr_addr),
    .wdata(arr_wdata),
    .rdata(arr_rdata)
  );

endmodule
`default_nettype wire

// *** bench/flash_guard_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checker with a shadow copy of the three registers.
module flash_guard_asserts
  import flash_guard_pkg::*;
#(
  parameter int WRITE_CYC = 4,
  parameter int ERASE_CYC = 600
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Register port.
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Core side.
  input wire logic CODE_RD,
  input wire logic DATA_MOVE_WR,
  input wire logic DATA_MOVE_RD,
  input wire logic [15:0] ACC_ADDR,
  input wire logic [15:0] ACC_PC,
  input wire logic [7:0] ACC_RDATA,
  input wire logic ACC_RVALID,
  input wire logic XRAM_SEL,
  input wire logic CORE_STALL,
  input wire logic SENSE_AMP_ON
);
  localparam int WL = WRITE_CYC + 1;
  // Shadow registers; set_r marks that the limit took its one write.
  logic [7:0] fc_r, fc_nxt, psc_r, psc_nxt, lim_r, lim_nxt;
  logic set_r, set_nxt;
  logic [15:0] lim_a;
  logic lower, write_ok;
  assign lim_a = {lim_r, LIMIT_LOW_BYTE};
  // Access from the upper partition aimed below the limit.
  assign lower = !psc_r[PSC_SCRATCHPAD_BIT] && ACC_PC >= lim_a && ACC_ADDR < lim_a;
  assign write_ok = DATA_MOVE_WR && !CORE_STALL && fc_r[0] && psc_r[0];
  // Next shadow values follow the accepted register writes.
  always_comb begin
    fc_nxt = fc_r;
    psc_nxt = psc_r;
    lim_nxt = lim_r;
    set_nxt = set_r;
    if (SFR_WR && SFR_ADDR == ADDR_FLASH_CONTROL) begin
      fc_nxt = SFR_WDATA & FC_WRITABLE_MASK;
    end
    if (SFR_WR && SFR_ADDR == ADDR_PROGRAM_STORE_CONTROL) begin
      psc_nxt = SFR_WDATA & PSC_WRITABLE_MASK;
    end
    if (SFR_WR && SFR_ADDR == ADDR_ACCESS_LIMIT && !set_r) begin
      lim_nxt = SFR_WDATA;
      set_nxt = 1'b1;
    end
  end
  // Shadow flops share the design's asynchronous reset.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fc_r <= RESET_FLASH_CONTROL;
      psc_r <= RESET_PROGRAM_STORE_CONTROL;
      lim_r <= RESET_ACCESS_LIMIT;
      set_r <= 1'b0;
    end else begin
      fc_r <= fc_nxt;
      psc_r <= psc_nxt;
      lim_r <= lim_nxt;
      set_r <= set_nxt;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_blocked_read_zero: assert property (CODE_RD && !CORE_STALL && lower |=>
    ACC_RVALID && ACC_RDATA == BLOCKED_BYTE) else $error("blocked read gave data");
  a_guarded_write_drop: assert property (write_ok && lower |=> !CORE_STALL)
    else $error("guarded write started");
  a_write_stall_len: assert property (write_ok && !lower && !psc_r[1] |=>
    CORE_STALL ##WL !CORE_STALL) else $error("write stall length off");
  a_no_enable_idle: assert property (DATA_MOVE_WR && !CORE_STALL &&
    !(fc_r[0] && psc_r[0]) |=> !CORE_STALL) else $error("disabled write ran");
  a_ctrl_readback: assert property (SFR_RD && SFR_ADDR == ADDR_FLASH_CONTROL |->
    SFR_RDATA == fc_r) else $error("flash control readback off");
  a_store_readback: assert property (SFR_RD && SFR_ADDR == ADDR_PROGRAM_STORE_CONTROL |->
    SFR_RDATA == psc_r) else $error("store control readback off");
  a_limit_first_only: assert property (SFR_RD && SFR_ADDR == ADDR_ACCESS_LIMIT |->
    SFR_RDATA == lim_r) else $error("limit readback off");
  a_move_read_ram: assert property (DATA_MOVE_RD |-> XRAM_SEL)
    else $error("data-move read left RAM");
  a_read_always_on: assert property (fc_r[FC_READ_ALWAYS_BIT] |-> SENSE_AMP_ON)
    else $error("sense amps off in read-always mode");
  c_write: cover property (write_ok && !lower);
  c_blocked: cover property (CODE_RD && lower);
  c_limit_again: cover property (SFR_WR && SFR_ADDR == ADDR_ACCESS_LIMIT && set_r);
endmodule
bind flash_access_guard flash_guard_asserts #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) chk (
  .CLK(CLK), .RST_B(RST_B), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .CODE_RD(CODE_RD),
  .DATA_MOVE_WR(DATA_MOVE_WR), .DATA_MOVE_RD(DATA_MOVE_RD), .ACC_ADDR(ACC_ADDR),
  .ACC_PC(ACC_PC), .ACC_RDATA(ACC_RDATA), .ACC_RVALID(ACC_RVALID), .XRAM_SEL(XRAM_SEL),
  .CORE_STALL(CORE_STALL), .SENSE_AMP_ON(SENSE_AMP_ON));
`default_nettype wire

// *** bench/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Core model: one access per call, never while the guard stalls it.
module core_model (
  // Clock and stall.
  input wire logic clk,
  input wire logic core_stall,
  // Requests toward the guard.
  output logic code_rd,
  output logic move_wr,
  output logic move_rd,
  output logic fetch,
  output logic [15:0] acc_addr,
  output logic [15:0] acc_pc,
  output logic [7:0] acc_wdata
);
  // Idle at time zero.
  initial begin
    {code_rd, move_wr, move_rd, fetch} = 4'h0;
    acc_addr = 16'h0000;
    acc_pc = 16'h0000;
    acc_wdata = 8'h00;
  end
  // Kind 0 code read, 1 data-move write, 2 data-move read, 3 fetch.
  task automatic issue(input logic [1:0] k, input logic [15:0] pc, input logic [15:0] a,
                       input logic [7:0] d);
    @(negedge clk);
    while (core_stall !== 1'b0) @(negedge clk);
    acc_pc = pc;
    acc_addr = a;
    acc_wdata = d;
    {fetch, move_rd, move_wr, code_rd} = 4'h1 << k;
    @(negedge clk);
    {fetch, move_rd, move_wr, code_rd} = 4'h0;
    // Released address and data lines show the inverse, so stale values cannot pass.
    acc_addr = ~a;
    acc_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// *** bench/flash_access_guard_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Self-checking bench; code-read results are matched through a queue.
module flash_access_guard_bench
  import flash_guard_pkg::*;
;
  logic clk, rst_b, sfr_wr, sfr_rd, jtag_erase;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc_wdata, acc_rdata, read_lock, write_lock, d, e;
  logic [15:0] acc_addr, acc_pc, jtag_addr;
  logic code_rd, move_wr, move_rd, fetch, acc_rvalid, xram_sel, core_stall, sense_on;
  logic [7:0] expect_q[$];
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // Short write and erase counts keep the run brief.
  flash_access_guard #(.WRITE_CYC(4), .ERASE_CYC(600)) dut (.CLK(clk), .RST_B(rst_b),
    .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
    .SFR_RDATA(sfr_rdata), .CODE_RD(code_rd), .DATA_MOVE_WR(move_wr), .DATA_MOVE_RD(move_rd),
    .FETCH(fetch), .ACC_ADDR(acc_addr), .ACC_PC(acc_pc), .ACC_WDATA(acc_wdata),
    .ACC_RDATA(acc_rdata), .ACC_RVALID(acc_rvalid), .XRAM_SEL(xram_sel),
    .CORE_STALL(core_stall), .JTAG_ERASE(jtag_erase), .JTAG_ADDR(jtag_addr),
    .SENSE_AMP_ON(sense_on), .READ_LOCK(read_lock), .WRITE_LOCK(write_lock));
  core_model core (.clk(clk), .core_stall(core_stall), .code_rd(code_rd), .move_wr(move_wr),
    .move_rd(move_rd), .fetch(fetch), .acc_addr(acc_addr), .acc_pc(acc_pc),
    .acc_wdata(acc_wdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ====================
  // Shared tasks.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  // Read data is combinational, so it is judged before the next falling edge.
  task automatic sfr_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    compare_byte(sfr_rdata, exp);
    @(negedge clk);
    sfr_rd = 1'b0;
  endtask
  task automatic rd(input logic [15:0] pc, input logic [15:0] a, input logic [7:0] exp);
    expect_q.push_back(exp);
    core.issue(2'd0, pc, a, 8'h00);
  endtask
  // A fetch also returns its byte with a valid pulse, so it is noted too.
  task automatic fe(input logic [15:0] pc, input logic [7:0] exp);
    expect_q.push_back(exp);
    core.issue(2'd3, pc, 16'h0000, 8'h00);
  endtask
  task automatic wait_idle();
    while (core_stall !== 1'b0) @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] pc, input logic [15:0] a, input logic [7:0] v);
    core.issue(2'd1, pc, a, v);
    wait_idle();
  endtask
  // Each valid read takes the oldest note off the queue.
  always @(negedge clk) begin
    if (acc_rvalid === 1'b1) begin
      if (expect_q.size() == 0) begin
        // A read that nobody asked for is always a mismatch.
        tests_run++;
        miscompares++;
        $display("wrong value at %0t: got %h expected no read", $time, acc_rdata);
      end else begin
        compare_byte(acc_rdata, expect_q.pop_front());
      end
    end
  end
  // A hang is counted as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ====================
  // Main sequence.
  initial begin
    {rst_b, sfr_wr, sfr_rd, jtag_erase} = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    jtag_addr = 16'h0000;
    d = 8'($urandom(9465));
    e = 8'($urandom());
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    sfr_check(ADDR_PROGRAM_STORE_CONTROL, 8'h00);
    sfr_check(ADDR_FLASH_CONTROL, 8'h80);
    sfr_check(ADDR_ACCESS_LIMIT, 8'h00);
    sfr_check(8'h00, 8'h00);
    sfr_write(ADDR_FLASH_CONTROL, 8'hff);
    sfr_check(ADDR_FLASH_CONTROL, 8'hc1);
    compare_byte({7'h00, sense_on}, 8'h01);
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'hfb);
    sfr_check(ADDR_PROGRAM_STORE_CONTROL, 8'h03);
    $display("test done: registers");
    sfr_write(ADDR_FLASH_CONTROL, 8'h81);
    wr(16'h0010, 16'h0400, d);
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'h01);
    wr(16'h0010, 16'h0402, d);
    wr(16'h0010, 16'h0402, e);
    rd(16'h0010, 16'h0402, d & e);
    rd(16'h0010, 16'h0401, ERASED_BYTE);
    rd(16'h0010, 16'h05ff, ERASED_BYTE);
    core.issue(2'd2, 16'h0010, 16'h0402, 8'h00);
    fe(16'h0402, d & e);
    $display("test done: program");
    sfr_write(ADDR_FLASH_CONTROL, 8'h80);
    wr(16'h0010, 16'h0404, 8'h00);
    rd(16'h0010, 16'h0404, ERASED_BYTE);
    repeat (4) @(negedge clk);
    compare_byte({7'h00, sense_on}, 8'h00);
    $display("test done: write enable");
    sfr_write(ADDR_ACCESS_LIMIT, 8'h06);
    sfr_write(ADDR_ACCESS_LIMIT, 8'h20);
    sfr_check(ADDR_ACCESS_LIMIT, 8'h06);
    rd(16'h0600, 16'h0402, BLOCKED_BYTE);
    rd(16'h05ff, 16'h0402, d & e);
    rd(16'h0700, 16'h05ff, BLOCKED_BYTE);
    fe(16'h0402, d & e);
    sfr_write(ADDR_FLASH_CONTROL, 8'h81);
    wr(16'h0600, 16'h0401, 8'h00);
    rd(16'h0010, 16'h0401, ERASED_BYTE);
    $display("test done: limit");
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'h07);
    wr(16'h0700, 16'h0010, 8'h00);
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'h05);
    wr(16'h0700, 16'h0011, d);
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'h04);
    rd(16'h0700, 16'h0011, d);
    rd(16'h0700, 16'h007f, ERASED_BYTE);
    $display("test done: scratchpad");
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'h01);
    wr(16'h0010, 16'hfdff, 8'h7f);
    compare_byte(read_lock, 8'h7f);
    wr(16'h0010, 16'hfdfe, 8'hfe);
    compare_byte(write_lock, 8'hfe);
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'h03);
    wr(16'h0010, 16'hfc10, 8'h00);
    compare_byte(read_lock, 8'h7f);
    sfr_write(ADDR_PROGRAM_STORE_CONTROL, 8'h01);
    wr(16'h0010, 16'hfc00, 8'h00);
    rd(16'h0010, 16'hfc00, 8'h00);
    @(negedge clk);
    jtag_addr = 16'hfc00;
    jtag_erase = 1'b1;
    @(negedge clk);
    jtag_erase = 1'b0;
    wait_idle();
    compare_byte(read_lock, 8'hff);
    compare_byte(write_lock, 8'hff);
    rd(16'h0010, 16'hfc00, ERASED_BYTE);
    rd(16'h0010, 16'h0402, d & e);
    repeat (3) @(negedge clk);
    compare_byte(8'(expect_q.size()), 8'h00);
    $display("test done: locks");
    give_verdict();
  end
endmodule
`default_nettype wire
